/* core/mprot_pkg.sv */
/*
 Package for the region memory protection unit: register map, attribute
 field layout, reset values and access structs. Assumes a 32-bit APB.
*/
package mprot_pkg;
   localparam int          NUM_REGIONS      = 8;
   localparam logic [11:0] OFS_CTRL         = 12'h000;
   localparam logic [11:0] OFS_COUNT        = 12'h004;
   localparam logic [11:0] OFS_FAULT        = 12'h008;
   localparam logic [11:0] OFS_FAULT_ADDR   = 12'h00C;
   localparam logic [11:0] OFS_REGION_BASE  = 12'h100;
   localparam logic [11:0] OFS_REGION_STEP  = 12'h008;
   localparam logic [11:0] OFS_REGION_ATTR  = 12'h004;
   localparam int          CTRL_ENABLE      = 0;
   localparam int          CTRL_PRIV_BG     = 1;
   localparam int          CTRL_FAULT_CHK   = 2;
   localparam int          ATTR_ON          = 0;
   localparam int          ATTR_SIZE_LSB    = 1;
   localparam int          ATTR_SIZE_W      = 5;
   localparam int          ATTR_SUB_LSB     = 8;
   localparam int          ATTR_PERM_LSB    = 24;
   localparam int          ATTR_XN          = 28;
   localparam logic [31:0] ATTR_WMASK       = 32'h17FF_FF3F;
   localparam logic [4:0]  size_code_smallest = 5'h04;
   localparam logic [4:0]  size_code_largest  = 5'h1F;
   localparam logic [4:0]  SIZE_SUB_MIN     = 5'h07;
   localparam logic [2:0]  perm_none_none   = 3'h0;
   localparam logic [2:0]  perm_rw_none     = 3'h1;
   localparam logic [2:0]  perm_rw_ro       = 3'h2;
   localparam logic [2:0]  perm_rw_rw       = 3'h3;
   localparam logic [2:0]  perm_ro_none     = 3'h5;
   localparam logic [2:0]  perm_ro_ro       = 3'h6;
   localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        write;
      logic        fetch;
      logic        priv;
      logic        in_fault_handler;
   } access_s;

   typedef struct packed {
      logic        fault;
      logic        bg_map;
      logic [31:0] addr;
   } verdict_s;
endpackage : mprot_pkg

/* core/region_match.sv */
/*
 One region's address and sub-region match with its permission check.
 Assumes the base is aligned to the region size, as software must keep.
*/
`timescale 1ns/1ps
`default_nettype none
module region_match (
   input  wire logic [31:0] i_base,
   input  wire logic [31:0] i_attr,
   input  wire logic [31:0] i_addr,
   input  wire logic        i_write,
   input  wire logic        i_fetch,
   input  wire logic        i_priv,
   output logic             o_hit,
   output logic             o_deny
);
   logic [4:0]  size;
   logic [32:0] span;
   logic [32:0] mask;
   logic [2:0]  sub_idx;
   logic        in_range;
   logic        sub_off;
   logic [2:0]  perm;
   logic        can_rd;
   logic        can_wr;

   always_comb begin
      size     = i_attr[mprot_pkg::ATTR_SIZE_LSB +: mprot_pkg::ATTR_SIZE_W];
      span     = 33'h0_0000_0002 << size;
      mask     = span - 33'h0_0000_0001;
      in_range = ((i_addr ^ i_base) & ~mask[31:0]) == 32'h0000_0000;
      sub_idx  = 3'((({1'b0, i_addr} & mask) >> (size - 5'h02)));
      sub_off  = (size >= mprot_pkg::SIZE_SUB_MIN)
                 && i_attr[mprot_pkg::ATTR_SUB_LSB + sub_idx];
      o_hit    = i_attr[mprot_pkg::ATTR_ON] && in_range && !sub_off;
      perm     = i_attr[mprot_pkg::ATTR_PERM_LSB +: 3];
      can_rd   = 1'b0;
      can_wr   = 1'b0;
      case (perm)
         mprot_pkg::perm_rw_none: begin
            can_rd = i_priv;
            can_wr = i_priv;
         end
         mprot_pkg::perm_rw_ro: begin
            can_rd = 1'b1;
            can_wr = i_priv;
         end
         mprot_pkg::perm_rw_rw: begin
            can_rd = 1'b1;
            can_wr = 1'b1;
         end
         mprot_pkg::perm_ro_none: begin
            can_rd = i_priv;
         end
         mprot_pkg::perm_ro_ro: begin
            can_rd = 1'b1;
         end
         default: begin
            can_rd = 1'b0;
         end
      endcase
      o_deny = (i_fetch && i_attr[mprot_pkg::ATTR_XN])
               || (i_write ? !can_wr : !can_rd);
   end
endmodule : region_match
`default_nettype wire

/* core/region_protect.sv */
/*
 Region memory protection unit: APB register file and per-access checker.
 Assumes the core presents one access per cycle and takes a registered
 verdict one cycle later.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module region_protect #(
   parameter int N_REGIONS = mprot_pkg::NUM_REGIONS
) (
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [11:0]        i_paddr,
   input  wire logic [31:0]        i_pwdata,
   input  wire logic [3:0]         i_pstrb,
   output logic                    o_pready,
   output logic [31:0]             o_prdata,
   output logic                    o_pslverr,
   input  wire mprot_pkg::access_s i_access,
   output mprot_pkg::verdict_s     o_verdict,
   output logic                    o_fault
);
   logic [31:0]          base [N_REGIONS];
   logic [31:0]          attr [N_REGIONS];
   logic [2:0]           ctrl;
   logic                 fault_sticky;
   logic [31:0]          fault_addr;
   logic [N_REGIONS-1:0] hit;
   logic [N_REGIONS-1:0] deny;
   logic                 win_hit;
   logic                 win_deny;
   logic                 checking;
   logic                 next_fault;
   logic                 next_bg;
   logic                 setup;
   logic                 access_ph;
   logic                 mapped;
   logic [31:0]          rd_word;
   logic [31:0]          wmask;
   logic                 region_sel;
   logic [2:0]           region_idx;
   logic                 is_attr;

   always_comb begin
      setup      = i_psel && !i_penable;
      access_ph  = i_psel && i_penable && o_pready;
      region_sel = (i_paddr >= mprot_pkg::OFS_REGION_BASE)
                   && (i_paddr < (mprot_pkg::OFS_REGION_BASE
                                  + 12'(N_REGIONS) * mprot_pkg::OFS_REGION_STEP));
      region_idx = 3'((i_paddr - mprot_pkg::OFS_REGION_BASE) >> 3);
      is_attr    = i_paddr[2];
      wmask      = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
      mapped     = 1'b1;
      rd_word    = mprot_pkg::RESET_WORD;
      if (i_paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end else if (i_paddr == mprot_pkg::OFS_CTRL) begin
         rd_word = {29'h0, ctrl};
      end else if (i_paddr == mprot_pkg::OFS_COUNT) begin
         rd_word = 32'(N_REGIONS);
      end else if (i_paddr == mprot_pkg::OFS_FAULT) begin
         rd_word = {31'h0, fault_sticky};
      end else if (i_paddr == mprot_pkg::OFS_FAULT_ADDR) begin
         rd_word = fault_addr;
      end else if (region_sel) begin
         rd_word = is_attr ? attr[region_idx] : base[region_idx];
      end else begin
         mapped = 1'b0;
      end
   end

   // Zero-wait slave: one setup cycle, answer in the first access cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= setup;
         o_pslverr <= setup && !mapped;
         o_prdata  <= (setup && !i_pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl <= 3'h0;
      end else if (access_ph && i_pwrite && i_paddr == mprot_pkg::OFS_CTRL && i_pstrb[0]) begin
         ctrl <= i_pwdata[2:0];
      end
   end

   // Region words only change on their own write, never on enable or disable
   generate
      for (genvar g = 0; g < N_REGIONS; g++) begin : g_region
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               base[g] <= mprot_pkg::RESET_WORD;
               attr[g] <= mprot_pkg::RESET_WORD;
            end else if (access_ph && i_pwrite && mapped && region_sel
                         && region_idx == 3'(g)) begin
               if (is_attr) begin
                  attr[g] <= ((i_pwdata & wmask) | (attr[g] & ~wmask))
                             & mprot_pkg::ATTR_WMASK;
               end else begin
                  base[g] <= (((i_pwdata & wmask) | (base[g] & ~wmask))
                              & 32'hFFFF_FFE0);
               end
            end
         end
         region_match u_match (
            .i_base  (base[g]),
            .i_attr  (attr[g]),
            .i_addr  (i_access.addr),
            .i_write (i_access.write),
            .i_fetch (i_access.fetch),
            .i_priv  (i_access.priv),
            .o_hit   (hit[g]),
            .o_deny  (deny[g])
         );

         a_region_kept: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            !(access_ph && i_pwrite && region_sel
              && region_idx == 3'(g))
            |=> ($stable(base[g]) && $stable(attr[g])))
            else $error("region words changed without a write");

         a_hit_off: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            !attr[g][mprot_pkg::ATTR_ON]
            |-> !hit[g])
            else $error("disabled region took part");

         a_read_attr: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (setup && !i_pwrite && mapped && region_sel
             && region_idx == 3'(g) && is_attr)
            |=> (o_prdata == attr[g]))
            else $error("attribute readback wrong");

         a_read_base: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (setup && !i_pwrite && mapped && region_sel
             && region_idx == 3'(g) && !is_attr)
            |=> (o_prdata == base[g]))
            else $error("base readback wrong");

         a_perm_open: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (attr[g][mprot_pkg::ATTR_PERM_LSB +: 3] == mprot_pkg::perm_rw_rw
             && !i_access.fetch)
            |-> !deny[g])
            else $error("full access denied");

         a_perm_shut: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (attr[g][mprot_pkg::ATTR_PERM_LSB +: 3] == mprot_pkg::perm_none_none)
            |-> deny[g])
            else $error("no-access region allowed an access");

         a_whole_small: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (attr[g][mprot_pkg::ATTR_ON]
             && attr[g][mprot_pkg::ATTR_SIZE_LSB +: mprot_pkg::ATTR_SIZE_W]
                < mprot_pkg::SIZE_SUB_MIN
             && ((i_access.addr ^ base[g])
                 >> (attr[g][mprot_pkg::ATTR_SIZE_LSB +: mprot_pkg::ATTR_SIZE_W]
                     + 6'h01)) == 32'h0000_0000)
            |-> hit[g])
            else $error("small region not checked as a whole");

         a_attr_lands: assert property (
            @(posedge i_clk) disable iff (!i_rstn)
            (access_ph && i_pwrite && mapped && region_sel
             && region_idx == 3'(g) && is_attr && i_pstrb[0])
            |=> (attr[g][mprot_pkg::ATTR_ON] == $past(i_pwdata[mprot_pkg::ATTR_ON])))
            else $error("enable bit not taken as written");
      end
   endgenerate

   always_comb begin
      win_hit  = 1'b0;
      win_deny = 1'b0;
      for (int k = 0; k < N_REGIONS; k++) begin
         if (hit[k]) begin
            win_hit  = 1'b1;
            win_deny = deny[k];
         end
      end
      checking = ctrl[mprot_pkg::CTRL_ENABLE]
                 && (!i_access.in_fault_handler
                     || ctrl[mprot_pkg::CTRL_FAULT_CHK]);
      next_fault = 1'b0;
      next_bg    = 1'b1;
      if (checking) begin
         if (win_hit) begin
            next_bg    = 1'b0;
            next_fault = win_deny;
         end else if (i_access.priv && ctrl[mprot_pkg::CTRL_PRIV_BG]) begin
            next_bg    = 1'b1;
         end else begin
            next_bg    = 1'b0;
            next_fault = 1'b1;
         end
      end
      next_fault = next_fault && i_access.valid;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_verdict <= '0;
         o_fault   <= 1'b0;
      end else begin
         o_verdict <= '{fault:  next_fault,
                        bg_map: next_bg && i_access.valid,
                        addr:   i_access.addr};
         o_fault   <= next_fault;
      end
   end

   // Fault capture: a new fault wins over a software clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fault_sticky <= 1'b0;
         fault_addr   <= 32'h0000_0000;
      end else if (next_fault) begin
         fault_sticky <= 1'b1;
         fault_addr   <= i_access.addr;
      end else if (access_ph && i_pwrite && i_paddr == mprot_pkg::OFS_FAULT && i_pwdata[0]) begin
         fault_sticky <= 1'b0;
      end
   end

   a_off_no_fault: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !$past(ctrl[mprot_pkg::CTRL_ENABLE])
      |-> !o_fault)
      else $error("fault while unit disabled");

   a_off_default_map: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid
       && !ctrl[mprot_pkg::CTRL_ENABLE])
      |=> (o_verdict.bg_map && !o_fault))
      else $error("default map not used while unit disabled");

   a_deny_faults: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && checking
       && win_hit && win_deny)
      |=> o_fault)
      else $error("violation not faulted");

   a_fault_sticky: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      o_fault
      |-> (fault_sticky && fault_addr == $past(i_access.addr)))
      else $error("fault not captured");

   a_idle_quiet: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !i_access.valid
      |=> (!o_fault && !o_verdict.bg_map))
      else $error("verdict without an access");

   a_bg_priv_ok: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && ctrl == 3'h3 && !win_hit
       && i_access.priv && !i_access.in_fault_handler)
      |=> (!o_fault && o_verdict.bg_map))
      else $error("background map not applied");

   a_handler_bypass: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.in_fault_handler
       && !ctrl[mprot_pkg::CTRL_FAULT_CHK])
      |=> !o_fault)
      else $error("fault inside handler with checks suspended");

   a_handler_map: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && i_access.in_fault_handler
       && !ctrl[mprot_pkg::CTRL_FAULT_CHK])
      |=> o_verdict.bg_map)
      else $error("default map not used inside handler");

   a_handler_check: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && i_access.in_fault_handler
       && ctrl == 3'h5 && !win_hit)
      |=> o_fault)
      else $error("handler miss not checked");

   a_miss_faults: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && checking
       && !win_hit && !i_access.priv)
      |=> o_fault)
      else $error("user miss did not fault");

   a_no_bg_priv: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && ctrl == 3'h1 && !win_hit
       && i_access.priv && !i_access.in_fault_handler)
      |=> (o_fault && !o_verdict.bg_map))
      else $error("privileged miss used a default map");

   a_count_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (setup && !i_pwrite
       && i_paddr == mprot_pkg::OFS_COUNT)
      |=> (o_pready && o_prdata == 32'(N_REGIONS)))
      else $error("region count wrong");

   a_exec_never: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && checking && hit[N_REGIONS-1] && i_access.fetch
       && attr[N_REGIONS-1][mprot_pkg::ATTR_XN])
      |=> o_fault)
      else $error("forbidden fetch allowed");

   a_top_wins: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_access.valid && checking
       && hit[N_REGIONS-1])
      |=> (o_fault == $past(deny[N_REGIONS-1])))
      else $error("highest region did not decide");
endmodule : region_protect
`default_nettype wire

/* testbench/core_model.sv */
/*
 Processor core model: presents one access per call to the protection unit.
 Assumes the caller reads the verdict itself after the call returns.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic               i_clk,
   output var mprot_pkg::access_s  o_access
);
   initial o_access = '0;
   // Idle fields flip so a stale address never looks valid
   task automatic issue(input logic [31:0] a, input logic w, f, p, h);
      @(posedge i_clk);
      o_access <= '{1'h1, a, w, f, p, h};
      @(posedge i_clk);
      o_access <= '{1'h0, ~a, ~w, ~f, ~p, ~h};
   endtask : issue
endmodule : core_model
`default_nettype wire

/* testbench/tb_top.sv */
/*
 Self-checking bench for the protection unit: APB master, random core
 accesses and a bench model of the verdict. Assumes package compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [2:0]  PERMS [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
   localparam logic [31:0] CTRLS [6] = '{32'h0, 32'h1, 32'h3, 32'h5, 32'h7, 32'h0};
   logic                i_clk = '0;
   logic                i_rstn = '0;
   logic                psel = '0;
   logic                penable = '0;
   logic                pwrite = '0;
   logic [11:0]         paddr = '0;
   logic [31:0]         pwdata = '0;
   logic [31:0]         prdata, rd, ctrl;
   logic                pready, pslverr, fault, err;
   mprot_pkg::access_s  access;
   mprot_pkg::verdict_s verdict;
   logic [31:0]         base [8];
   logic [31:0]         attr [8];
   int                  errors = 0;
   int                  checks = 0;
   int                  cyc = 0;
   logic [31:0]         last_fault = '0;
   logic                seen_fault = '0;
   integer              seed = 32'hB831FBD2;

   region_protect region_protect_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(4'hF), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_access(access), .o_verdict(verdict), .o_fault(fault));
   core_model core_model_i (.i_clk(i_clk), .o_access(access));

   always #5 i_clk = ~i_clk;
   // Ceiling well above the roughly two thousand cycles the run needs
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (exp !== got) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'h1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'h1);
      chk("pready_wait", 1, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Attribute write only, so the stored base must survive untouched
   task automatic region(input int i, input logic [31:0] a);
      logic [11:0] ra;
      ra = 12'(mprot_pkg::OFS_REGION_BASE + 8 * i);
      attr[i] = a;
      apb(1, ra + mprot_pkg::OFS_REGION_ATTR, a);
      apb(0, ra, 0);
      chk("base", base[i], rd);
      apb(0, ra + mprot_pkg::OFS_REGION_ATTR, 0);
      chk("attr", a, rd);
   endtask : region

   // Returns {fault, default map used}
   function automatic logic [1:0] expect_v(input logic [31:0] a, input logic w, f, p, h);
      int hit, sz;
      logic [2:0] pm;
      logic ok;
      hit = -1;
      if (ctrl[0] !== 1'h1 || (h && !ctrl[2])) return 2'h1;
      for (int i = 0; i < 8; i++) begin
         sz = attr[i][5:1] + 1;
         if (attr[i][0] && (64'(a) >> sz) == (64'(base[i]) >> sz) &&
             !(sz >= 8 && attr[i][8 + ((a >> (sz - 3)) & 7)]))
            hit = i;
      end
      if (hit < 0) return (p && ctrl[1]) ? 2'h1 : 2'h2;
      pm = attr[hit][26:24];
      if (f && attr[hit][28]) return 2'h2;
      ok = p ? (w ? pm inside {1, 2, 3} : pm inside {1, 2, 3, 5, 6})
             : (w ? pm == 3 : pm inside {2, 3, 6});
      return {~ok, 1'h0};
   endfunction : expect_v

   // Addresses biased into one region so hits and sub-regions are common
   task automatic probe(input int k);
      logic [31:0] a;
      logic        w, f, p, h;
      logic [1:0]  e;
      a = base[k] | (32'($random(seed)) & 32'((64'h1 << (attr[k][5:1] + 1)) - 1));
      f = 1'($random(seed));
      w = f ? 1'h0 : 1'($random(seed));
      p = 1'($random(seed));
      h = ($random(seed) & 7) == 0;
      e = expect_v(a, w, f, p, h);
      if (e[1]) begin
         seen_fault = 1'h1;
         last_fault = a;
      end
      core_model_i.issue(a, w, f, p, h);
      #1;
      chk("fault", e[1], verdict.fault);
      chk("bg_map", e[0], verdict.bg_map);
      chk("o_fault", e[1], fault);
      chk("addr", a, verdict.addr);
   endtask : probe

   initial begin
      logic [4:0] code;
      repeat (20) @(posedge i_clk);
      i_rstn <= 1'h1;
      ctrl = '0;
      apb(0, mprot_pkg::OFS_COUNT, 0);
      chk("count", mprot_pkg::NUM_REGIONS, rd);
      apb(0, 12'h010, 0);
      chk("slverr", 1, err);
      // Smallest, largest and both sides of the sub-region limit
      for (int i = 0; i < 8; i++) begin
         code = i == 0 ? 5'h1F : i == 1 ? 5'h04 : i == 2 ? 5'h06 : i == 3 ? 5'h07
              : 5'(4 + ($unsigned($random(seed)) % 28));
         base[i] = $random(seed) & 32'(~((64'h1 << (code + 1)) - 1));
         apb(1, 12'(mprot_pkg::OFS_REGION_BASE + 8 * i), base[i]);
         region(i, {3'h0, 1'($random(seed)), 1'h0, PERMS[$unsigned($random(seed)) % 6],
                    8'h0, 8'($random(seed)), 2'h0, code, 1'h1});
      end
      foreach (CTRLS[c]) begin
         ctrl = CTRLS[c];
         apb(1, mprot_pkg::OFS_CTRL, ctrl);
         region(c, attr[c] ^ 32'h1);
         repeat (150) probe($unsigned($random(seed)) % 8);
         // Sticky flag and address, then a clear that the next test sees
         apb(0, mprot_pkg::OFS_FAULT, 0);
         chk("fault_flag", 32'(seen_fault), rd);
         apb(0, mprot_pkg::OFS_FAULT_ADDR, 0);
         chk("fault_addr", last_fault, rd);
         apb(1, mprot_pkg::OFS_FAULT, 1);
         seen_fault = 1'h0;
         $display("test ctrl=%h done errors=%0d", ctrl, errors);
      end
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
